// >>> core/aidr_pkg.sv
/*
  Package for the analog input diagnostic record block: record byte indices,
  field positions, constant descriptor values and timing counts.
  Assumes a 25 MHz system clock.
*/
package aidr_pkg;
  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam int CLK_HZ = 25_000_000;
  localparam int TICK_NS = 1000;
  localparam int CLK_PERIOD_NS = 1_000_000_000 / CLK_HZ;
  localparam int TICK_CYCLES = TICK_NS / CLK_PERIOD_NS;
  localparam logic [4:0] TICK_LAST = 5'(TICK_CYCLES - 1);

  // ------------------------------------------------------------
  // Record byte indices (diagnostic record, byte addressed)
  // ------------------------------------------------------------
  localparam logic [4:0] IDX_MODULE_EXT_DIAG = 5'h03;
  localparam logic [4:0] IDX_CHANNEL_TYPE = 5'h04;
  localparam logic [4:0] IDX_BITS_PER_CH = 5'h05;
  localparam logic [4:0] IDX_CHANNEL_COUNT = 5'h06;
  localparam logic [4:0] IDX_GROUP_SUMMARY = 5'h07;
  localparam logic [4:0] IDX_CH0_ERROR = 5'h08;
  localparam logic [4:0] IDX_CH1_ERROR = 5'h09;
  localparam logic [4:0] IDX_UNUSED_FIRST = 5'h0a;
  localparam logic [4:0] IDX_UNUSED_LAST = 5'h0f;
  localparam logic [4:0] IDX_TIMESTAMP = 5'h10;
  localparam logic [4:0] IDX_TIMESTAMP_LAST = 5'h13;

  // ------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------
  localparam int EXT_BUF_OVERFLOW = 3;
  localparam int EXT_COMM_ERROR = 4;
  localparam int EXT_IRQ_LOST = 6;
  localparam int CHE_PARAM = 0;
  localparam int CHE_RAW_HIGH = 1;
  localparam int CHE_RAW_LOW = 2;
  localparam int CHE_SENSOR_SUPPLY = 4;
  localparam int CHE_IRQ_LOST = 5;
  localparam int CHE_RANGE_UNDER = 6;
  localparam int CHE_RANGE_OVER = 7;

  // ------------------------------------------------------------
  // Constant values and reset values
  // ------------------------------------------------------------
  localparam logic [6:0] CHTYPE_DIGITAL_IN = 7'h70;
  localparam logic [6:0] CHTYPE_ANALOG_IN = 7'h71;
  localparam logic [6:0] CHTYPE_DIGITAL_OUT = 7'h72;
  localparam logic [6:0] CHTYPE_ANALOG_OUT = 7'h73;
  localparam logic [6:0] CHTYPE_ANALOG_INOUT = 7'h74;
  localparam logic [6:0] CHTYPE_COUNTER = 7'h76;
  localparam logic [7:0] BITS_PER_CH_VALUE = 8'h08;
  localparam logic [7:0] CHANNEL_COUNT_VALUE = 8'h02;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [31:0] TICKER_RESET = 32'h0000_0000;
  localparam logic [15:0] WORD_RESET = 16'h0000;
  localparam logic [15:0] ADC_MASK = 16'h0fff;
  localparam int NUM_CH = 2;
  localparam int ADC_BITS = 12;
  localparam int OUT_IMAGE_BYTES = 0;
endpackage : aidr_pkg

// >>> core/aidr_record.sv
/*
  Diagnostic record and input image of a two channel 12-bit analog input
  module. Error causes arrive as levels from logic on the same clock; the
  conversion results arrive as 12-bit words with a one-cycle valid strobe.
  The record is read a byte at a time by index, answer one cycle later.
*/
`timescale 1ns/1ps
module aidr_record
  import aidr_pkg::*;
(
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic buf_overflow_i,
  input wire logic comm_error_i,
  input wire logic irq_lost_i,
  input wire logic bus_ok_i,
  input wire logic [1:0] param_err_i,
  input wire logic [1:0] raw_high_i,
  input wire logic [1:0] raw_low_i,
  input wire logic [1:0] supply_err_i,
  input wire logic [1:0] ch_irq_lost_i,
  input wire logic [1:0] range_under_i,
  input wire logic [1:0] range_over_i,
  input wire logic [1:0] sample_valid_i,
  input wire logic [23:0] sample_data_i,
  input wire logic rd_en_i,
  input wire logic [4:0] rd_index_i,
  input wire logic img_rd_en_i,
  input wire logic [1:0] img_addr_i,
  output logic [7:0] rd_data_o,
  output logic [7:0] img_data_o,
  output logic [15:0] analog_value_ch0_o,
  output logic [15:0] analog_value_ch1_o,
  output logic [31:0] ticker_o,
  output logic diag_active_o,
  output logic run_indicator_o,
  output logic fault_indicator_o,
  output logic [1:0] channel_indicator_o,
  output logic [7:0] out_image_bytes_o
);

  // ------------------------------------------------------------
  // Microsecond ticker
  // ------------------------------------------------------------
  logic [4:0] tick_div;
  logic [31:0] ticker;

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      tick_div <= 5'h00;
    end else if (tick_div == TICK_LAST) begin
      tick_div <= 5'h00;
    end else begin
      tick_div <= tick_div + 5'h01;
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      ticker <= TICKER_RESET;
    end else if (tick_div == TICK_LAST) begin
      ticker <= ticker + 32'h0000_0001; // Natural wrap
    end
  end

  // ------------------------------------------------------------
  // Live diagnostic bytes
  // ------------------------------------------------------------
  // Bytes follow their causes directly so a going diagnostic needs no
  // acknowledge from the coupler.
  logic [7:0] ext_diag;
  logic [7:0] ch_err [NUM_CH];
  logic [7:0] next_ext_diag;
  logic [7:0] next_ch_err [NUM_CH];
  logic [7:0] group_summary;
  logic any_diag;

  always_comb begin
    next_ext_diag = BYTE_RESET;
    next_ext_diag[EXT_BUF_OVERFLOW] = buf_overflow_i;
    next_ext_diag[EXT_COMM_ERROR] = comm_error_i;
    next_ext_diag[EXT_IRQ_LOST] = irq_lost_i;
  end

  genvar g;
  generate
    for (g = 0; g < NUM_CH; g++) begin : g_ch
      always_comb begin
        next_ch_err[g] = BYTE_RESET; // Bit 3 stays zero
        next_ch_err[g][CHE_PARAM] = param_err_i[g];
        next_ch_err[g][CHE_RAW_HIGH] = raw_high_i[g];
        next_ch_err[g][CHE_RAW_LOW] = raw_low_i[g];
        next_ch_err[g][CHE_SENSOR_SUPPLY] = supply_err_i[g];
        next_ch_err[g][CHE_IRQ_LOST] = ch_irq_lost_i[g];
        next_ch_err[g][CHE_RANGE_UNDER] = range_under_i[g];
        next_ch_err[g][CHE_RANGE_OVER] = range_over_i[g];
      end

      always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
          ch_err[g] <= BYTE_RESET;
        end else begin
          ch_err[g] <= next_ch_err[g]; // Self clearing
        end
      end

      always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
          channel_indicator_o[g] <= 1'b0;
        end else begin
          channel_indicator_o[g] <= range_under_i[g] | range_over_i[g] | param_err_i[g];
        end
      end

    end
  endgenerate

  // ------------------------------------------------------------
  // Analog value words
  // ------------------------------------------------------------
  // Only the 12 result bits are kept; upper bits read zero.
  // One process per word so each output has a single driver.
  logic [11:0] sample_ch0;
  logic [11:0] sample_ch1;

  assign sample_ch0 = sample_data_i[11:0];
  assign sample_ch1 = sample_data_i[23:12];

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      analog_value_ch0_o <= WORD_RESET;
    end else if (sample_valid_i[0]) begin
      analog_value_ch0_o <= {4'h0, sample_ch0};
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      analog_value_ch1_o <= WORD_RESET;
    end else if (sample_valid_i[1]) begin
      analog_value_ch1_o <= {4'h0, sample_ch1};
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      ext_diag <= BYTE_RESET;
    end else begin
      ext_diag <= next_ext_diag;
    end
  end

  always_comb begin
    group_summary = BYTE_RESET;
    group_summary[0] = |ch_err[0];
    group_summary[1] = |ch_err[1];
  end

  assign any_diag = (|ext_diag) | (|group_summary);

  // ------------------------------------------------------------
  // Timestamp and fault indicator
  // ------------------------------------------------------------
  // Events during an active window are not stored: the stamp is taken only
  // on the first incoming diagnostic.
  logic [31:0] diag_timestamp;

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      diag_active_o <= 1'b0;
    end else begin
      diag_active_o <= any_diag;
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      diag_timestamp <= TICKER_RESET;
    end else if (any_diag && !diag_active_o) begin
      diag_timestamp <= ticker;
    end
  end

  // Fault lamp also covers a dead bus, so it is lit with run dark
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      fault_indicator_o <= 1'b0;
    end else begin
      fault_indicator_o <= any_diag | !bus_ok_i;
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      run_indicator_o <= 1'b0;
    end else begin
      run_indicator_o <= bus_ok_i;
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      ticker_o <= TICKER_RESET;
    end else begin
      ticker_o <= ticker;
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      out_image_bytes_o <= BYTE_RESET;
    end else begin
      out_image_bytes_o <= 8'(OUT_IMAGE_BYTES);
    end
  end

  // ------------------------------------------------------------
  // Record read port
  // ------------------------------------------------------------
  function automatic logic [7:0] stamp_byte(input logic [31:0] v, input logic [1:0] sel);
    logic [7:0] b;
    b = v[8*sel +: 8];
    return b;
  endfunction : stamp_byte

  logic [7:0] next_rd_data;

  always_comb begin
    next_rd_data = BYTE_RESET; // Unmapped and reserved read zero
    if (rd_index_i == IDX_MODULE_EXT_DIAG) begin
      next_rd_data = ext_diag;
    end else if (rd_index_i == IDX_CHANNEL_TYPE) begin
      next_rd_data = {1'b0, CHTYPE_ANALOG_IN};
    end else if (rd_index_i == IDX_BITS_PER_CH) begin
      next_rd_data = BITS_PER_CH_VALUE;
    end else if (rd_index_i == IDX_CHANNEL_COUNT) begin
      next_rd_data = CHANNEL_COUNT_VALUE;
    end else if (rd_index_i == IDX_GROUP_SUMMARY) begin
      next_rd_data = group_summary;
    end else if (rd_index_i == IDX_CH0_ERROR) begin
      next_rd_data = ch_err[0];
    end else if (rd_index_i == IDX_CH1_ERROR) begin
      next_rd_data = ch_err[1];
    end else if (rd_index_i >= IDX_UNUSED_FIRST && rd_index_i <= IDX_UNUSED_LAST) begin
      next_rd_data = BYTE_RESET;
    end else if (rd_index_i >= IDX_TIMESTAMP && rd_index_i <= IDX_TIMESTAMP_LAST) begin
      // Most significant byte first
      next_rd_data = stamp_byte(diag_timestamp, 2'(IDX_TIMESTAMP_LAST - rd_index_i));
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      rd_data_o <= BYTE_RESET;
    end else if (rd_en_i) begin
      rd_data_o <= next_rd_data;
    end
  end

  // ------------------------------------------------------------
  // Input image read port
  // ------------------------------------------------------------
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      img_data_o <= BYTE_RESET;
    end else if (img_rd_en_i) begin
      case (img_addr_i)
        2'h0: img_data_o <= analog_value_ch0_o[7:0];
        2'h1: img_data_o <= analog_value_ch0_o[15:8];
        2'h2: img_data_o <= analog_value_ch1_o[7:0];
        default: img_data_o <= analog_value_ch1_o[15:8];
      endcase
    end
  end

endmodule : aidr_record

// >>> tb/aidr_coupler.sv
/*
  Bus coupler model: reads record and image bytes one at a time.
  Assumes answers come one cycle after the request edge.
*/
`timescale 1ns/1ps
module aidr_coupler (
  input wire logic mclk_i,
  input wire logic [7:0] rd_data_i,
  input wire logic [7:0] img_data_i,
  output logic rd_en_o,
  output logic [4:0] rd_index_o,
  output logic img_rd_en_o,
  output logic [1:0] img_addr_o
);
  initial begin
    rd_en_o = 1'b0;
    rd_index_o = 5'h00;
    img_rd_en_o = 1'b0;
    img_addr_o = 2'h0;
  end

  task automatic rd_rec(input logic [4:0] idx, output logic [7:0] data);
    @(posedge mclk_i) #1;
    rd_en_o = 1'b1;
    rd_index_o = idx;
    @(posedge mclk_i) #1;
    rd_en_o = 1'b0;
    data = rd_data_i;
  endtask : rd_rec

  task automatic rd_img(input logic [1:0] addr, output logic [7:0] data);
    @(posedge mclk_i) #1;
    img_rd_en_o = 1'b1;
    img_addr_o = addr;
    @(posedge mclk_i) #1;
    img_rd_en_o = 1'b0;
    data = img_data_i;
  endtask : rd_img
endmodule : aidr_coupler

// >>> tb/aidr_record_assertions.sv
/*
  Port checker for the analog input diagnostic record.
  Assumes one clock, mclk_i, and rst_i asynchronous active high.
*/
`timescale 1ns/1ps
module aidr_record_assertions
  import aidr_pkg::*;
(
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic bus_ok_i,
  input wire logic [1:0] range_over_i,
  input wire logic [1:0] sample_valid_i,
  input wire logic [23:0] sample_data_i,
  input wire logic rd_en_i,
  input wire logic [4:0] rd_index_i,
  input wire logic [7:0] rd_data_o,
  input wire logic [15:0] analog_value_ch0_o,
  input wire logic [31:0] ticker_o,
  input wire logic fault_indicator_o,
  input wire logic [1:0] channel_indicator_o,
  input wire logic [7:0] out_image_bytes_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);

  a_type_code: assert property (rd_en_i && rd_index_i == IDX_CHANNEL_TYPE |=> rd_data_o == 8'h71)
    else $error("channel type byte wrong");
  a_bits_const: assert property (rd_en_i && rd_index_i == IDX_BITS_PER_CH |=> rd_data_o == 8'h08)
    else $error("bits per channel byte wrong");
  a_count_const: assert property (rd_en_i && rd_index_i == IDX_CHANNEL_COUNT |=> rd_data_o == 8'h02)
    else $error("channel count byte wrong");
  a_unused_zero: assert property (rd_en_i && rd_index_i >= IDX_UNUSED_FIRST && rd_index_i <= IDX_UNUSED_LAST
    |=> rd_data_o == 8'h00)
    else $error("unused channel byte not zero");
  a_fault_busdown: assert property (!bus_ok_i |=> fault_indicator_o)
    else $error("fault lamp dark with bus down");
  a_no_outimage: assert property (out_image_bytes_o == 8'h00)
    else $error("output image size not zero");
  a_sample_load: assert property (sample_valid_i[0] |=> analog_value_ch0_o == {4'h0, $past(sample_data_i[11:0])})
    else $error("channel 0 value not loaded");
  a_ticker_step: assert property (ticker_o != $past(ticker_o) |-> ticker_o == $past(ticker_o) + 32'h0000_0001)
    else $error("ticker did not step by one");
  a_ticker_gap: assert property (ticker_o != $past(ticker_o) |=> $stable(ticker_o) [*8])
    else $error("ticker stepped too soon");
  a_chan_lamp: assert property (range_over_i[0] |=> channel_indicator_o[0])
    else $error("channel lamp dark on overflow");
endmodule : aidr_record_assertions

bind aidr_record aidr_record_assertions chk (.mclk_i, .rst_i, .bus_ok_i, .range_over_i, .sample_valid_i,
  .sample_data_i, .rd_en_i, .rd_index_i, .rd_data_o, .analog_value_ch0_o, .ticker_o, .fault_indicator_o,
  .channel_indicator_o, .out_image_bytes_o);

// >>> tb/aidr_record_bench.sv
/*
  Self-checking bench for the analog input diagnostic record.
  Assumes the coupler model answers reads; causes are driven here.
*/
`timescale 1ns/1ps
module aidr_record_bench;
  import aidr_pkg::*;
  logic mclk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [2:0] mod_err = 3'h0;
  logic bus_ok = 1'b1;
  logic [1:0] ch_err [7];
  logic [1:0] s_valid = 2'h0;
  logic [23:0] s_data = 24'h00_0000;
  logic rd_en, img_en;
  logic [4:0] rd_index;
  logic [1:0] img_addr;
  logic [7:0] rd_data, img_data, b;
  logic [15:0] v0, v1;
  logic [31:0] ticker, stamp, stamp2;
  logic run_led, fault_led, diag_act;
  logic [1:0] ch_led;
  int mismatches = 0;
  int cmp_count = 0;
  int edges = 0;
  int bitpos [7] = '{0, 1, 2, 4, 5, 6, 7};
  int modpos [3] = '{3, 4, 6};

  always #20 mclk_i = ~mclk_i;
  always @(posedge mclk_i) if (!rst_i) edges <= edges + 1;
  initial foreach (ch_err[i]) ch_err[i] = 2'h0;

  aidr_record dut (.mclk_i(mclk_i), .rst_i(rst_i), .buf_overflow_i(mod_err[0]), .comm_error_i(mod_err[1]),
    .irq_lost_i(mod_err[2]), .bus_ok_i(bus_ok), .param_err_i(ch_err[0]), .raw_high_i(ch_err[1]),
    .raw_low_i(ch_err[2]), .supply_err_i(ch_err[3]), .ch_irq_lost_i(ch_err[4]), .range_under_i(ch_err[5]),
    .range_over_i(ch_err[6]), .sample_valid_i(s_valid), .sample_data_i(s_data), .rd_en_i(rd_en),
    .rd_index_i(rd_index), .img_rd_en_i(img_en), .img_addr_i(img_addr), .rd_data_o(rd_data),
    .img_data_o(img_data), .analog_value_ch0_o(v0), .analog_value_ch1_o(v1), .ticker_o(ticker),
    .diag_active_o(diag_act), .run_indicator_o(run_led), .fault_indicator_o(fault_led),
    .channel_indicator_o(ch_led), .out_image_bytes_o());
  aidr_coupler coupler (.mclk_i(mclk_i), .rd_data_i(rd_data), .img_data_i(img_data), .rd_en_o(rd_en),
    .rd_index_o(rd_index), .img_rd_en_o(img_en), .img_addr_o(img_addr));

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic step(input int n);
    repeat (n) @(posedge mclk_i) #1;
  endtask : step

  task automatic rd_stamp(output logic [31:0] ts);
    for (int i = 0; i < 4; i++) begin
      coupler.rd_rec(IDX_TIMESTAMP + 5'(i), b);
      ts = {ts[23:0], b};
    end
  endtask : rd_stamp

  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : wrap_up

  initial begin
    #2_000_000;
    mismatches++;
    wrap_up;
  end

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    step(8);
    rst_i = 1'b0;
    step(1);
    // Idle record: descriptors and zero bytes
    for (int i = 3; i < 16; i++) begin
      coupler.rd_rec(5'(i), b);
      chk("idle byte", b, i == 4 ? 8'h71 : i == 5 ? 8'h08 : i == 6 ? 8'h02 : 8'h00);
    end
    // Module causes: stamp first, later event not stamped
    for (int i = 0; i < 30 && edges % 25 != 10; i++) step(1);
    chk("ticker", ticker, 32'((edges - 1) / 25));
    stamp2 = 32'(edges / 25);
    for (int k = 0; k < 3; k++) begin
      mod_err[k] = 1'b1;
      step(2);
      coupler.rd_rec(IDX_MODULE_EXT_DIAG, b);
      chk("ext diag", b, 32'(1 << modpos[k]) | (k > 0 ? 32'(1 << modpos[k - 1]) : 0));
      chk("fault lamp", fault_led, 1'b1);
      chk("diag active", diag_act, 1'b1);
      if (k > 0) mod_err[k - 1] = 1'b0;
      if (k == 0) step(60);
    end
    rd_stamp(stamp);
    chk("timestamp", stamp, stamp2);
    mod_err = 3'h0;
    step(2);
    coupler.rd_rec(IDX_MODULE_EXT_DIAG, b);
    chk("ext diag clear", b, 8'h00);
    chk("fault lamp off", fault_led, 1'b0);
    chk("diag inactive", diag_act, 1'b0);
    // Channel causes, one bit at a time on each channel
    for (int c = 0; c < 2; c++) begin
      for (int k = 0; k < 7; k++) begin
        ch_err[k][c] = 1'b1;
        step(2);
        coupler.rd_rec(IDX_CH0_ERROR + 5'(c), b);
        chk("channel byte", b, 32'(1 << bitpos[k]));
        coupler.rd_rec(IDX_GROUP_SUMMARY, b);
        chk("summary", b, 32'(1 << c));
        chk("channel lamp", ch_led, (k == 0 || k >= 5) ? 32'(1 << c) : 0);
        ch_err[k][c] = 1'b0;
      end
    end
    step(2);
    coupler.rd_rec(IDX_GROUP_SUMMARY, b);
    chk("summary clear", b, 8'h00);
    // Samples and input image
    s_valid = 2'h3;
    s_data = 24'h123_abc;
    step(1);
    s_valid = 2'h0;
    s_data = 24'hfff_fff;
    step(1);
    chk("value ch0", v0, 16'h0abc);
    chk("value ch1", v1, 16'h0123);
    for (int a = 0; a < 4; a++) begin
      coupler.rd_img(2'(a), b);
      chk("image byte", b, a == 0 ? 8'hbc : a == 1 ? 8'h0a : a == 2 ? 8'h23 : 8'h01);
    end
    // Bus down lamps
    bus_ok = 1'b0;
    step(2);
    chk("run lamp", run_led, 1'b0);
    chk("fault bus down", fault_led, 1'b1);
    bus_ok = 1'b1;
    step(2);
    wrap_up;
  end
endmodule : aidr_record_bench
